// ---- rtl/sbtrim_regs.vh ----
// Offsets, field positions, reset values and decode codes of the trim registers
`ifndef SBTRIM_REGS_VH
`define SBTRIM_REGS_VH

// ----------------------------------------
// Address windows
// ----------------------------------------
`define SBTRIM_BASE_BLOCKING 16'h0200
`define SBTRIM_BASE_NONBLOCKING 16'h0300
`define SBTRIM_WINDOW_MASK 16'hff00
`define SBTRIM_OFFS_SLEEP_BANDGAP_TRIM 8'hf2
`define SBTRIM_OFFS_ADC_OFFSET_TRIM 8'hf3

// ----------------------------------------
// Sleep bandgap trim fields
// ----------------------------------------
`define SBTRIM_SLEEP_ENABLE_BIT 4
`define SBTRIM_SLEEP_LOCK_BIT 3
`define SBTRIM_SLEEP_CODE_MSB 2
`define SBTRIM_SLEEP_CODE_LSB 0
`define SBTRIM_SLEEP_RESET 8'h00
`define SBTRIM_SLEEP_RW_MASK 8'h1f
`define SBTRIM_SLEEP_CODE_DEFAULT 3'h0

// ----------------------------------------
// ADC offset trim fields
// ----------------------------------------
`define SBTRIM_ADC_ENABLE_BIT 7
`define SBTRIM_ADC_CODE_MSB 6
`define SBTRIM_ADC_CODE_LSB 4
`define SBTRIM_ADC_SPARE_MSB 3
`define SBTRIM_ADC_SPARE_LSB 0
`define SBTRIM_ADC_RESET 8'h00
`define SBTRIM_ADC_CODE_DEFAULT 3'h0

// ----------------------------------------
// Sleep trim step index (signed tenths of percent)
// ----------------------------------------
`define SBTRIM_SLP_M122 8'h86
`define SBTRIM_SLP_M82 8'hae
`define SBTRIM_SLP_M42 8'hd6
`define SBTRIM_SLP_0 8'h00
`define SBTRIM_SLP_P42 8'h2a
`define SBTRIM_SLP_P83 8'h53
`define SBTRIM_SLP_P125 8'h7d

// ----------------------------------------
// ADC offset step (signed hundredths of percent)
// ----------------------------------------
`define SBTRIM_ADC_0 13'h0000
`define SBTRIM_ADC_P798 13'h031e
`define SBTRIM_ADC_P1597 13'h063d
`define SBTRIM_ADC_P2395 13'h095b
`define SBTRIM_ADC_M2395 13'h16a5
`define SBTRIM_ADC_M1597 13'h19c3
`define SBTRIM_ADC_M798 13'h1ce2

`endif

// ---- rtl/sbtrim_bank.v ----
// Sleep bandgap and ADC offset trim register bank on the die-to-die register port
`timescale 1ns/100ps
`include "sbtrim_regs.vh"
module sbtrim_bank (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [15:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_hit,
    // Analog trim outputs
    output reg [2:0] sleep_mode_reference,
    output reg [7:0] sleep_trim_step,
    output reg sleep_trim_locked,
    output reg [2:0] adc_offset_compensation,
    output reg [12:0] adc_offset_step,
    output reg [3:0] spare_trim
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg [7:0] sleep_bandgap_trim;
    reg [7:0] adc_offset_trim;
    reg [7:0] next_sleep;
    reg [7:0] next_adc;
    reg [7:0] next_rdata;
    reg [2:0] next_slp_code;
    reg [2:0] next_adc_code;
    reg [7:0] next_slp_step;
    reg [12:0] next_adc_step;
    wire win_hit;
    wire sel_sleep;
    wire sel_adc;
    wire wr_sleep;
    wire wr_adc;
    wire rd_sleep;
    wire rd_adc;
    wire sleep_locked;
    wire sleep_enabled;
    wire adc_enabled;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    assign win_hit = ((reg_addr & `SBTRIM_WINDOW_MASK) == `SBTRIM_BASE_BLOCKING) ||
                     ((reg_addr & `SBTRIM_WINDOW_MASK) == `SBTRIM_BASE_NONBLOCKING);
    assign sel_sleep = win_hit && (reg_addr[7:0] == `SBTRIM_OFFS_SLEEP_BANDGAP_TRIM);
    assign sel_adc = win_hit && (reg_addr[7:0] == `SBTRIM_OFFS_ADC_OFFSET_TRIM);
    assign sleep_locked = sleep_bandgap_trim[`SBTRIM_SLEEP_LOCK_BIT];
    assign sleep_enabled = sleep_bandgap_trim[`SBTRIM_SLEEP_ENABLE_BIT];
    assign adc_enabled = adc_offset_trim[`SBTRIM_ADC_ENABLE_BIT];

    // ----------------------------------------
    // Access strobes
    // ----------------------------------------
    assign wr_sleep = sel_sleep && reg_write;
    assign wr_adc = sel_adc && reg_write;
    assign rd_sleep = sel_sleep && reg_read;
    assign rd_adc = sel_adc && reg_read;

    // ----------------------------------------
    // Sleep trim write policy
    // ----------------------------------------
    always @* begin
        next_sleep = sleep_bandgap_trim;
        if (wr_sleep && !sleep_locked) begin
            if (reg_wdata[`SBTRIM_SLEEP_ENABLE_BIT]) begin
                // Code and lock may be set together with enable
                next_sleep = reg_wdata & `SBTRIM_SLEEP_RW_MASK;
            end else begin
                // Enable cleared: default code 0 applied (step SBTRIM_SLP_M122), code and lock held at default
                next_sleep = `SBTRIM_SLEEP_RESET;
            end
        end
    end

    // ----------------------------------------
    // ADC trim write policy
    // ----------------------------------------
    always @* begin
        next_adc = adc_offset_trim;
        if (wr_adc) begin
            // Whole byte kept; the enable only gates the applied code
            next_adc = reg_wdata;
        end
    end

    // ----------------------------------------
    // Sleep trim register; kept in low power, cleared by reset or by an unlocked write with enable clear
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_bandgap_trim <= `SBTRIM_SLEEP_RESET;
        end else begin
            sleep_bandgap_trim <= next_sleep;
        end
    end

    // ----------------------------------------
    // ADC trim register; kept in low power, cleared by reset only
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_offset_trim <= `SBTRIM_ADC_RESET;
        end else begin
            adc_offset_trim <= next_adc;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always @* begin
        next_rdata = 8'h00;
        if (rd_sleep) begin
            next_rdata = sleep_bandgap_trim & `SBTRIM_SLEEP_RW_MASK;
        end else if (rd_adc) begin
            next_rdata = adc_offset_trim;
        end
    end

    // ----------------------------------------
    // Trim decode
    // ----------------------------------------
    always @* begin
        next_slp_code = sleep_enabled ?
            sleep_bandgap_trim[`SBTRIM_SLEEP_CODE_MSB:`SBTRIM_SLEEP_CODE_LSB] :
            `SBTRIM_SLEEP_CODE_DEFAULT;
        next_adc_code = adc_enabled ?
            adc_offset_trim[`SBTRIM_ADC_CODE_MSB:`SBTRIM_ADC_CODE_LSB] :
            `SBTRIM_ADC_CODE_DEFAULT;
    end

    // ----------------------------------------
    // Sleep trim step table
    // ----------------------------------------
    always @* begin
        case (next_slp_code)
            3'h0: next_slp_step = `SBTRIM_SLP_M122;
            3'h1: next_slp_step = `SBTRIM_SLP_M82;
            3'h2: next_slp_step = `SBTRIM_SLP_M42;
            3'h3: next_slp_step = `SBTRIM_SLP_0;
            3'h4: next_slp_step = `SBTRIM_SLP_P42;
            3'h5: next_slp_step = `SBTRIM_SLP_P83;
            3'h6: next_slp_step = `SBTRIM_SLP_P125;
            default: next_slp_step = `SBTRIM_SLP_M122;
        endcase
    end

    // ----------------------------------------
    // ADC offset step table
    // ----------------------------------------
    always @* begin
        case (next_adc_code)
            3'h0: next_adc_step = `SBTRIM_ADC_0;
            3'h1: next_adc_step = `SBTRIM_ADC_P798;
            3'h2: next_adc_step = `SBTRIM_ADC_P1597;
            3'h3: next_adc_step = `SBTRIM_ADC_P2395;
            3'h4: next_adc_step = `SBTRIM_ADC_M2395;
            3'h5: next_adc_step = `SBTRIM_ADC_M1597;
            3'h6: next_adc_step = `SBTRIM_ADC_M798;
            default: next_adc_step = `SBTRIM_ADC_0;
        endcase
    end

    // ----------------------------------------
    // Register port outputs
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_hit <= rd_sleep || rd_adc || wr_sleep || wr_adc;
        end
    end

    // ----------------------------------------
    // Applied sleep trim outputs
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_mode_reference <= `SBTRIM_SLEEP_CODE_DEFAULT;
            sleep_trim_step <= `SBTRIM_SLP_M122;
            sleep_trim_locked <= 1'b0;
        end else begin
            sleep_mode_reference <= next_slp_code;
            sleep_trim_step <= next_slp_step;
            sleep_trim_locked <= sleep_locked;
        end
    end

    // ----------------------------------------
    // Applied ADC trim outputs
    // ----------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_offset_compensation <= `SBTRIM_ADC_CODE_DEFAULT;
            adc_offset_step <= `SBTRIM_ADC_0;
            spare_trim <= 4'h0;
        end else begin
            adc_offset_compensation <= next_adc_code;
            adc_offset_step <= next_adc_step;
            spare_trim <= adc_offset_trim[`SBTRIM_ADC_SPARE_MSB:`SBTRIM_ADC_SPARE_LSB];
        end
    end

endmodule // sbtrim_bank

// ---- bench/sbtrim_bank_assertions.sv ----
// Port checks of the trim register bank
`timescale 1ns/100ps
`include "sbtrim_regs.vh"
module sbtrim_chk (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [15:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_hit,
    // Trim outputs
    input wire [2:0] sleep_mode_reference,
    input wire [7:0] sleep_trim_step,
    input wire sleep_trim_locked,
    input wire [2:0] adc_offset_compensation,
    input wire [12:0] adc_offset_step,
    input wire [3:0] spare_trim
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire adr = (reg_addr[15:8] == 8'h02 || reg_addr[15:8] == 8'h03) && reg_addr[7:1] == 7'h79;
    wire acc = (reg_write || reg_read) && adr;
    wire w2 = reg_write && adr && !reg_addr[0];
    wire w3 = reg_write && adr && reg_addr[0];
    sequence s_slp_wr; w2 && !sleep_trim_locked && !$past(w2); endsequence
    sequence s_adc_wr; w3; endsequence
    property p_slp;
        logic [7:0] d;
        (s_slp_wr, d = reg_wdata) |=> ##1 sleep_mode_reference == (d[4] ? d[2:0] : 3'h0)
            && sleep_trim_locked == (d[4] && d[3]);
    endproperty
    property p_adc;
        logic [7:0] d;
        (s_adc_wr, d = reg_wdata) |=> ##1 adc_offset_compensation == (d[7] ? d[6:4] : 3'h0)
            && spare_trim == d[3:0];
    endproperty
    AST_HIT: assert property (acc |=> reg_hit)
        else $error("hit missing");
    AST_MISS: assert property (!acc |=> !reg_hit)
        else $error("stray hit");
    AST_RDZ: assert property (!(reg_read && adr) |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    AST_SLP: assert property (p_slp)
        else $error("sleep trim output wrong");
    AST_LOCK: assert property (sleep_trim_locked && w2 |=> ##1 $stable(sleep_mode_reference))
        else $error("locked trim changed");
    AST_KEEP: assert property (sleep_trim_locked |=> sleep_trim_locked)
        else $error("lock dropped");
    AST_ADC: assert property (p_adc)
        else $error("adc trim output wrong");
    AST_ASTEP: assert property (adc_offset_compensation == 3'h1 |-> adc_offset_step == `SBTRIM_ADC_P798)
        else $error("adc step wrong");
    AST_SSTEP: assert property (sleep_mode_reference == 3'h0 |-> sleep_trim_step == `SBTRIM_SLP_M122)
        else $error("sleep step wrong");
endmodule // sbtrim_chk
bind sbtrim_bank sbtrim_chk chk (.*);

// ---- bench/sbtrim_host.sv ----
// Host model driving the register port
`timescale 1ns/100ps
module sbtrim_host (
    // Clock
    input wire clk,
    // Register port
    output logic [15:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_write = w;
        reg_read = !w;
        @(posedge clk);
        #1;
        q = reg_rdata;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule // sbtrim_host

// ---- bench/sbtrim_bank_tb_top.sv ----
// Self-checking bench of the trim register bank
`timescale 1ns/100ps
`include "sbtrim_regs.vh"
module sbtrim_bank_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    wire [15:0] a;
    wire w;
    wire r;
    wire [7:0] wd;
    wire [7:0] rd;
    wire [2:0] smr;
    wire [7:0] sts;
    wire stl;
    wire [2:0] aoc;
    wire [12:0] aos;
    wire hit;
    wire [3:0] spt;
    logic [7:0] q;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] slp_tab [8] = '{`SBTRIM_SLP_M122, `SBTRIM_SLP_M82, `SBTRIM_SLP_M42,
        `SBTRIM_SLP_0, `SBTRIM_SLP_P42, `SBTRIM_SLP_P83, `SBTRIM_SLP_P125, `SBTRIM_SLP_M122};
    logic [12:0] adc_tab [8] = '{`SBTRIM_ADC_0, `SBTRIM_ADC_P798, `SBTRIM_ADC_P1597,
        `SBTRIM_ADC_P2395, `SBTRIM_ADC_M2395, `SBTRIM_ADC_M1597, `SBTRIM_ADC_M798, `SBTRIM_ADC_0};
    sbtrim_host host (.clk(clk), .reg_addr(a), .reg_write(w), .reg_read(r), .reg_wdata(wd),
        .reg_rdata(rd));
    sbtrim_bank uut (.clk(clk), .reset_n(reset_n), .reg_addr(a), .reg_write(w), .reg_read(r),
        .reg_wdata(wd), .reg_rdata(rd), .reg_hit(hit), .sleep_mode_reference(smr),
        .sleep_trim_step(sts), .sleep_trim_locked(stl), .adc_offset_compensation(aoc),
        .adc_offset_step(aos), .spare_trim(spt));
    initial begin
        forever #10 clk = ~clk;
    end
    task chk(input string n, input logic [12:0] e, input logic [12:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [15:0] ad, input logic [7:0] d);
        host.xfer(1'b1, ad, d, q);
        @(posedge clk);
        #1;
    endtask
    task t_rst;
        #1;
        reset_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk("sleep step", {5'h00, `SBTRIM_SLP_M122}, {5'h00, sts});
        host.xfer(1'b0, 16'h02f2, 8'h00, q);
        chk("sleep reg", 13'h0000, {5'h00, q});
        chk("hit", 13'h0001, {12'h000, hit});
        host.xfer(1'b0, 16'h02f3, 8'h00, q);
        chk("adc reg", 13'h0000, {5'h00, q});
        $display("test reset done");
    endtask
    task t_window;
        wr(16'h02f3, 8'h1a);
        host.xfer(1'b0, 16'h03f3, 8'h00, q);
        chk("adc reg", 13'h001a, {5'h00, q});
        chk("spare", 13'h000a, {9'h000, spt});
        chk("adc code", 13'h0000, {10'h000, aoc});
        chk("adc step", `SBTRIM_ADC_0, aos);
        wr(16'h04f3, 8'hff);
        host.xfer(1'b0, 16'h02f3, 8'h00, q);
        chk("adc reg", 13'h001a, {5'h00, q});
        host.xfer(1'b0, 16'h04f3, 8'h00, q);
        chk("unmapped", 13'h0000, {5'h00, q});
        chk("hit", 13'h0000, {12'h000, hit});
        $display("test window done");
    endtask
    task t_adc;
        for (int i = 0; i < 8; i++) begin
            wr(16'h03f3, {1'b1, i[2:0], 4'h5});
            chk("adc code", {10'h000, i[2:0]}, {10'h000, aoc});
            chk("adc step", adc_tab[i], aos);
        end
        $display("test adc done");
    endtask
    task t_sleep;
        for (int i = 0; i < 8; i++) begin
            wr(16'h02f2, {5'h02, i[2:0]});
            chk("sleep code", {10'h000, i[2:0]}, {10'h000, smr});
            chk("sleep step", {5'h00, slp_tab[i]}, {5'h00, sts});
        end
        wr(16'h02f2, 8'h0d);
        chk("sleep code", 13'h0000, {10'h000, smr});
        chk("lock", 13'h0000, {12'h000, stl});
        wr(16'h03f2, 8'h1b);
        chk("lock", 13'h0001, {12'h000, stl});
        wr(16'h02f2, 8'h16);
        host.xfer(1'b0, 16'h02f2, 8'h00, q);
        chk("sleep reg", 13'h001b, {5'h00, q});
        chk("sleep code", 13'h0003, {10'h000, smr});
        $display("test sleep done");
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_rst();
        t_window();
        t_adc();
        t_sleep();
        t_rst();
        stop_test();
    end
endmodule // sbtrim_bank_tb_top
